// ===== tmuz_unit.sv
/*
 type 0 math unit datapath: multiply and divide by two pi, division and
 square root, with input conditioning and the sticky flags.
 assumes the host reads the source registers named by src_b_idx and
 src_c_idx in the issue cycle and writes back the results it is given.
*/
`timescale 1ns/1ns
module tmuz_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // issue
   input wire logic issue_valid,
   input wire tmuz_pkg::tmuz_instr_t instr,
   input wire logic [31:0] src_b,
   input wire logic [31:0] src_c,
   output logic op_accept,
   output logic [2:0] src_b_idx,
   output logic [2:0] src_c_idx,
   // results
   output tmuz_pkg::tmuz_res_t fwd_res,
   output tmuz_pkg::tmuz_res_t short_res,
   output tmuz_pkg::tmuz_res_t long_res,
   // flags
   input wire logic fpu_set_ovf,
   input wire logic fpu_set_unf,
   input wire logic flag_load,
   input wire logic flag_load_ovf,
   input wire logic flag_load_unf,
   output logic latched_overflow_flag,
   output logic latched_underflow_flag
);
   // nan to signed infinity, zero and denormals to plus zero
   function automatic logic [31:0] cond(input logic [31:0] x);
      logic [31:0] r;
      r = x;
      if (x[30:23] == tmuz_pkg::EXP_ALL1) begin
         r = {x[31], tmuz_pkg::EXP_ALL1, 23'h000000};
      end else if (x[30:23] == 8'h00) begin
         r = 32'h00000000;
      end
      return r;
   endfunction : cond

   // returns {ovf, unf, data}; chk selects the overflow or underflow check
   function automatic logic [33:0] mul_k(input logic [31:0] a, input logic [31:0] k,
                                         input logic chk);
      logic [47:0] p;
      logic signed [10:0] e;
      logic [22:0] f;
      logic [33:0] r;
      p = {1'b1, a[22:0]} * {1'b1, k[22:0]};
      e = $signed({3'b000, a[30:23]}) + $signed({3'b000, k[30:23]}) - tmuz_pkg::BIAS;
      if (p[47]) begin
         f = p[46:24];
         e = e + 11'sh001;
      end else begin
         f = p[45:23];
      end
      r = {2'b00, a[31] ^ k[31], e[7:0], f};
      if (a[30:23] == 8'h00) begin
         r = 34'h000000000;
      end else if (chk && e > tmuz_pkg::EXP_MAX) begin
         r = {2'b10, a[31] ^ k[31], tmuz_pkg::EXP_ALL1, 23'h000000};
      end else if (!chk && e < 11'sh000) begin
         r = {2'b01, 32'h00000000};
      end
      return r;
   endfunction : mul_k

   // b / c, returns {ovf, unf, data}
   function automatic logic [33:0] fdiv(input logic [31:0] b, input logic [31:0] c);
      logic zb, zc, ib, ic, s;
      logic [47:0] q;
      logic signed [10:0] e;
      logic [22:0] f;
      logic [33:0] r;
      zb = (b[30:23] == 8'h00);
      zc = (c[30:23] == 8'h00);
      ib = (b[30:23] == tmuz_pkg::EXP_ALL1);
      ic = (c[30:23] == tmuz_pkg::EXP_ALL1);
      s = b[31] ^ c[31];
      q = {1'b1, b[22:0], 24'h000000} / {24'h000000, 1'b1, c[22:0]};
      e = $signed({3'b000, b[30:23]}) - $signed({3'b000, c[30:23]}) + tmuz_pkg::BIAS;
      if (!q[24]) begin
         e = e - 11'sh001;
         f = q[22:0];
      end else begin
         f = q[23:1];
      end
      r = {2'b00, s, e[7:0], f};
      if (e >= tmuz_pkg::EXP_MAX) begin
         r = {2'b10, s, tmuz_pkg::EXP_ALL1, 23'h000000};
      end else if (e < 11'sh000 || (e == 11'sh000 && f != 23'h000000)) begin
         r = {2'b01, 32'h00000000};
      end
      // operand specials take priority over the generic path
      if (zb && zc) begin
         r = {2'b10, 32'h00000000};
      end else if (zb && ic) begin
         r = {2'b01, 32'h00000000};
      end else if (ib && ic) begin
         r = {2'b01, s, tmuz_pkg::EXP_ALL1, 23'h000000};
      end else if (ib || zc) begin
         r = {2'b10, s, tmuz_pkg::EXP_ALL1, 23'h000000};
      end else if (ic) begin
         r = {2'b01, 32'h00000000};
      end else if (zb) begin
         r = {2'b00, 32'h00000000};
      end
      return r;
   endfunction : fdiv

   // bit-serial root search, unrolled; slow but small in text
   function automatic logic [33:0] fsqrt(input logic [31:0] b);
      logic signed [10:0] u;
      logic [47:0] rad;
      logic [23:0] root, trial;
      logic [33:0] r;
      u = $signed({3'b000, b[30:23]}) - tmuz_pkg::BIAS;
      rad = u[0] ? {1'b1, b[22:0], 24'h000000} : {1'b0, 1'b1, b[22:0], 23'h000000};
      root = 24'h000000;
      for (int i = 23; i >= 0; i--) begin
         trial = root | (24'h000001 << i);
         if ({24'h000000, trial} * {24'h000000, trial} <= {48'h0, rad}) begin
            root = trial;
         end
      end
      u = (u >>> 1) + tmuz_pkg::BIAS;
      r = {2'b00, 1'b0, u[7:0], root[22:0]};
      if (b[30:23] == 8'h00) begin
         r = 34'h000000000;
      end else if (b[31]) begin
         r = {2'b10, 32'h00000000};
      end else if (b[30:23] == tmuz_pkg::EXP_ALL1) begin
         r = {2'b10, 1'b0, tmuz_pkg::EXP_ALL1, 23'h000000};
      end
      return r;
   endfunction : fsqrt

   // decode
   logic is_mul, is_d2p, is_div, is_sqrt, two_ok, three_ok;
   logic [31:0] cb, cc;
   logic [33:0] short_calc, long_calc;
   assign two_ok = (instr.hi[15:tmuz_pkg::TWO_OP_TOP] == 10'h000);
   assign three_ok = (instr.hi[15:tmuz_pkg::THREE_OP_TOP] == 7'h00);
   assign is_mul = issue_valid && instr.lo == tmuz_pkg::OP_MUL2PI && two_ok;
   assign is_d2p = issue_valid && instr.lo == tmuz_pkg::OP_DIV2PI && two_ok;
   assign is_div = issue_valid && instr.lo == tmuz_pkg::OP_FDIV && three_ok;
   assign is_sqrt = issue_valid && instr.lo == tmuz_pkg::OP_FSQRT && two_ok;
   assign op_accept = is_mul || is_d2p || is_div || is_sqrt;
   assign src_b_idx = instr.hi[tmuz_pkg::SRCB_LSB +: 3];
   assign src_c_idx = instr.hi[tmuz_pkg::SRCC_LSB +: 3];

   // conditioned operands feed every operation, flags untouched here
   assign cb = cond(src_b);
   assign cc = cond(src_c);
   assign short_calc = is_mul ? mul_k(cb, tmuz_pkg::TWO_PI, 1'b1)
                              : mul_k(cb, tmuz_pkg::INV_TWO_PI, 1'b0);
   assign long_calc = is_div ? fdiv(cb, cc) : fsqrt(cb);

   // result pipes: separate write ports so short and long never collide
   tmuz_pkg::tmuz_res_t short_q_ff [tmuz_pkg::LAT_SHORT];
   tmuz_pkg::tmuz_res_t nxt_short_q [tmuz_pkg::LAT_SHORT];
   tmuz_pkg::tmuz_res_t long_q_ff [tmuz_pkg::LAT_LONG];
   tmuz_pkg::tmuz_res_t nxt_long_q [tmuz_pkg::LAT_LONG];
   always_comb begin
      nxt_short_q[0].valid = is_mul || is_d2p;
      nxt_short_q[0].dest = instr.hi[tmuz_pkg::DST_LSB +: 3];
      nxt_short_q[0].data = short_calc[31:0];
      nxt_short_q[0].ovf = short_calc[33];
      nxt_short_q[0].unf = short_calc[32];
      for (int i = 1; i < tmuz_pkg::LAT_SHORT; i++) begin
         nxt_short_q[i] = short_q_ff[i-1];
      end
      nxt_long_q[0].valid = is_div || is_sqrt;
      nxt_long_q[0].dest = instr.hi[tmuz_pkg::DST_LSB +: 3];
      nxt_long_q[0].data = long_calc[31:0];
      nxt_long_q[0].ovf = long_calc[33];
      nxt_long_q[0].unf = long_calc[32];
      for (int i = 1; i < tmuz_pkg::LAT_LONG; i++) begin
         nxt_long_q[i] = long_q_ff[i-1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < tmuz_pkg::LAT_SHORT; i++) begin
            short_q_ff[i] <= '0;
         end
         for (int i = 0; i < tmuz_pkg::LAT_LONG; i++) begin
            long_q_ff[i] <= '0;
         end
      end else begin
         short_q_ff <= nxt_short_q;
         long_q_ff <= nxt_long_q;
      end
   end

   // early copy for sine, cosine and store consumers
   assign fwd_res = short_q_ff[tmuz_pkg::LAT_FWD-1];
   assign short_res = short_q_ff[tmuz_pkg::LAT_SHORT-1];
   assign long_res = long_q_ff[tmuz_pkg::LAT_LONG-1];

   // sticky flags: sets win over a host load in the same cycle
   logic ovf_ff, unf_ff, nxt_ovf, nxt_unf, set_ovf, set_unf;
   always_comb begin
      set_ovf = fpu_set_ovf || (short_res.valid && short_res.ovf) ||
                (long_res.valid && long_res.ovf);
      set_unf = fpu_set_unf || (short_res.valid && short_res.unf) ||
                (long_res.valid && long_res.unf);
      nxt_ovf = (flag_load ? flag_load_ovf : ovf_ff) || set_ovf;
      nxt_unf = (flag_load ? flag_load_unf : unf_ff) || set_unf;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
         unf_ff <= 1'b0;
      end else begin
         ovf_ff <= nxt_ovf;
         unf_ff <= nxt_unf;
      end
   end
   assign latched_overflow_flag = ovf_ff;
   assign latched_underflow_flag = unf_ff;

   // checks
   sequence s_short_issue;
      is_mul || is_d2p;
   endsequence
   sequence s_long_issue;
      is_div || is_sqrt;
   endsequence
   a_short_write: assert property (@(posedge clk) disable iff (!rst_n)
      s_short_issue |-> ##3 short_res.valid) else $error("short result late");
   a_fwd_early: assert property (@(posedge clk) disable iff (!rst_n)
      s_short_issue |-> ##2 fwd_res.valid ##1 short_res.valid)
      else $error("forward copy not at two");
   // back to back long issues keep the port busy, so only the landing cycle is pinned
   a_long_write: assert property (@(posedge clk) disable iff (!rst_n)
      s_long_issue |-> ##5 long_res.valid)
      else $error("long result not at five");
   a_mul_dest: assert property (@(posedge clk) disable iff (!rst_n)
      is_mul |-> ##3 short_res.dest == $past(instr.hi[2:0], 3))
      else $error("wrong destination");
   a_mul_ovf_inf: assert property (@(posedge clk) disable iff (!rst_n)
      short_res.valid && short_res.ovf |-> short_res.data[30:0] == 31'h7f800000)
      else $error("overflow without infinity");
   a_d2p_unf: assert property (@(posedge clk) disable iff (!rst_n)
      short_res.valid && short_res.unf |-> short_res.data == 32'h00000000)
      else $error("underflow without zero");
   a_negzero_in: assert property (@(posedge clk) disable iff (!rst_n)
      is_mul && src_b == 32'h80000000 |->
      ##3 short_res.data == 32'h00000000 && !short_res.ovf && !short_res.unf)
      else $error("negative zero not conditioned");
   a_sqrt_neg: assert property (@(posedge clk) disable iff (!rst_n)
      is_sqrt && src_b[31] && src_b[30:23] != 8'h00 |->
      ##5 long_res.data == 32'h00000000 && long_res.ovf)
      else $error("negative root wrong");
   a_div_zz: assert property (@(posedge clk) disable iff (!rst_n)
      is_div && src_b[30:23] == 8'h00 && src_c[30:23] == 8'h00 |->
      ##5 long_res.data == 32'h00000000 && long_res.ovf && !long_res.unf)
      else $error("zero over zero wrong");
   a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      ovf_ff && !flag_load |=> ovf_ff) else $error("overflow flag dropped");
   a_unf_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      unf_ff && !flag_load |=> unf_ff) else $error("underflow flag dropped");
   // a set must survive a host load in the same cycle
   a_ovf_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      fpu_set_ovf || (long_res.valid && long_res.ovf) |=> ovf_ff)
      else $error("overflow set lost");
   a_unf_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
      fpu_set_unf || (short_res.valid && short_res.unf) |=> unf_ff)
      else $error("underflow set lost");
   // long overflow results are either zero or an infinity, never a nonzero finite value
   a_long_ovf_shape: assert property (@(posedge clk) disable iff (!rst_n)
      long_res.valid && long_res.ovf |->
      long_res.data == 32'h00000000 || long_res.data[30:0] == 31'h7f800000)
      else $error("long overflow not clamped");
   a_long_unf_zero: assert property (@(posedge clk) disable iff (!rst_n)
      long_res.valid && long_res.unf && long_res.data[30:23] != 8'hff |->
      long_res.data == 32'h00000000)
      else $error("long underflow not zero");
   // refused words must not enter the first stage of either pipe
   a_refuse_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      issue_valid && !op_accept |=> !short_q_ff[0].valid && !long_q_ff[0].valid)
      else $error("refused word entered a pipe");
endmodule : tmuz_unit

// ===== tmuz_pkg.sv
/*
 holds opcodes, field positions, constants, latencies and carrier types
 for the type 0 math unit; assumes ieee single-precision operands.
*/
package tmuz_pkg;
   // instruction low words
   localparam logic [15:0] OP_MUL2PI = 16'he270;
   localparam logic [15:0] OP_DIV2PI = 16'he271;
   localparam logic [15:0] OP_FDIV = 16'he274;
   localparam logic [15:0] OP_FSQRT = 16'he277;
   // high word field positions
   localparam int DST_LSB = 0;
   localparam int SRCB_LSB = 3;
   localparam int SRCC_LSB = 6;
   localparam int TWO_OP_TOP = 6;
   localparam int THREE_OP_TOP = 9;
   // single-precision constants
   localparam logic [31:0] TWO_PI = 32'h40c90fdb;
   localparam logic [31:0] INV_TWO_PI = 32'h3e22f983;
   localparam logic [7:0] EXP_ALL1 = 8'hff;
   localparam logic signed [10:0] BIAS = 11'sh07f;
   localparam logic signed [10:0] EXP_MAX = 11'sh0ff;
   // pipeline depths in cycles
   localparam int LAT_FWD = 2;
   localparam int LAT_SHORT = 3;
   localparam int LAT_LONG = 5;
   // issued instruction
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } tmuz_instr_t;
   // one result on its way to the register file
   typedef struct packed {
      logic valid;
      logic [2:0] dest;
      logic [31:0] data;
      logic ovf;
      logic unf;
   } tmuz_res_t;
endpackage : tmuz_pkg

// ===== tmuz_host_model.sv
/*
 host side of the math unit: eight float registers read by index in the
 issue cycle and written back from the result ports; one clock domain.
*/
`timescale 1ns/1ns
module tmuz_host_model (
   // clock
   input wire logic clk,
   // operand reads
   input wire logic [2:0] src_b_idx,
   input wire logic [2:0] src_c_idx,
   output logic [31:0] src_b,
   output logic [31:0] src_c,
   // write-back
   input wire tmuz_pkg::tmuz_res_t short_res,
   input wire tmuz_pkg::tmuz_res_t long_res
);
   logic [31:0] fregs [8];
   // operands are read without a register, as the unit expects
   assign src_b = fregs[src_b_idx];
   assign src_c = fregs[src_c_idx];
   // write-back only; the bench fills sources between edges
   always @(posedge clk) begin
      if (short_res.valid) fregs[short_res.dest] <= short_res.data;
      if (long_res.valid) fregs[long_res.dest] <= long_res.data;
   end
endmodule : tmuz_host_model

// ===== tmuz_unit_bench.sv
/*
 self-checking bench for the math unit: directed corner cases, refusals
 and random power-of-two operands; assumes the host model beside it.
*/
`timescale 1ns/1ns
module tmuz_unit_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic issue_valid = 1'b0;
   tmuz_pkg::tmuz_instr_t instr = '0;
   logic fpu_set_ovf = 1'b0, fpu_set_unf = 1'b0, flag_load = 1'b0;
   logic flag_load_ovf = 1'b0, flag_load_unf = 1'b0;
   logic op_accept, lovf, lunf;
   logic [2:0] src_b_idx, src_c_idx;
   logic [31:0] src_b, src_c;
   tmuz_pkg::tmuz_res_t fwd_res, short_res, long_res;
   // expected results by arrival cycle, empty until an issue lands there
   tmuz_pkg::tmuz_res_t sf [16] = '{default: '0};
   tmuz_pkg::tmuz_res_t ss [16] = '{default: '0};
   tmuz_pkg::tmuz_res_t sl [16] = '{default: '0};
   logic e_ovf = 1'b0, e_unf = 1'b0, sb, sc;
   logic [2:0] b;
   int cyc = 0, last_iss = -100, seed = 96, error_cnt = 0, total_checks = 0;
   int i, eb, ec;
   logic [15:0] ops [4] = '{tmuz_pkg::OP_MUL2PI, tmuz_pkg::OP_DIV2PI,
      tmuz_pkg::OP_FDIV, tmuz_pkg::OP_FSQRT};
   // op index, source, divisor, result, ovf/unf
   logic [99:0] dir [18] = '{
      {2'd0, 32'h80000000, 32'h0, 32'h00000000, 2'b00},
      {2'd0, 32'h00000001, 32'h0, 32'h00000000, 2'b00},
      {2'd1, 32'h80400000, 32'h0, 32'h00000000, 2'b00},
      {2'd0, 32'hffc00000, 32'h0, 32'hff800000, 2'b10},
      {2'd1, 32'h7fc00000, 32'h0, 32'h7e22f983, 2'b00},
      {2'd0, 32'h7f000000, 32'h0, 32'h7f800000, 2'b10},
      {2'd1, 32'h00800000, 32'h0, 32'h00000000, 2'b01},
      {2'd2, 32'h40000000, 32'h3fc00000, 32'h3faaaaaa, 2'b00},
      {2'd2, 32'hc0c00000, 32'h40000000, 32'hc0400000, 2'b00},
      {2'd2, 32'h80000000, 32'h00000001, 32'h00000000, 2'b10},
      {2'd2, 32'h00000000, 32'h7f800000, 32'h00000000, 2'b01},
      {2'd2, 32'h7f800000, 32'h40000000, 32'h7f800000, 2'b10},
      {2'd2, 32'hff800000, 32'h00000000, 32'hff800000, 2'b10},
      {2'd2, 32'h7f800000, 32'hff800000, 32'hff800000, 2'b01},
      {2'd2, 32'h40000000, 32'h00000000, 32'h7f800000, 2'b10},
      {2'd2, 32'h40000000, 32'h7fc00000, 32'h00000000, 2'b01},
      {2'd3, 32'hff800000, 32'h0, 32'h00000000, 2'b10},
      {2'd3, 32'h7f800000, 32'h0, 32'h7f800000, 2'b10}
   };

   tmuz_unit tmuz_unit_i (.clk, .rst_n, .issue_valid, .instr, .src_b, .src_c,
      .op_accept, .src_b_idx, .src_c_idx, .fwd_res, .short_res, .long_res,
      .fpu_set_ovf, .fpu_set_unf, .flag_load, .flag_load_ovf, .flag_load_unf,
      .latched_overflow_flag(lovf), .latched_underflow_flag(lunf));
   tmuz_host_model tmuz_host_model_i (.clk, .src_b_idx, .src_c_idx, .src_b,
      .src_c, .short_res, .long_res);

   // clock, cycle count and hang guard
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic check(input logic [37:0] seen, input logic [37:0] want);
      total_checks++;
      if (seen !== want) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
   endtask : check

   // expected result of a power-of-two operand, truncating mantissas
   function automatic logic [33:0] pow2(input logic [15:0] lo, input logic sb, sc,
         input int eb, ec);
      int e;
      if (lo == tmuz_pkg::OP_MUL2PI) begin
         e = eb + 2;
         return (e > 255) ? {sb, 31'h7f800000, 2'b10} : {sb, 8'(e), 23'h490fdb, 2'b00};
      end
      if (lo == tmuz_pkg::OP_DIV2PI) begin
         e = eb - 3;
         return (e < 0) ? {32'h0, 2'b01} : {sb, 8'(e), 23'h22f983, 2'b00};
      end
      if (lo == tmuz_pkg::OP_FDIV) begin
         e = eb - ec + 127;
         if (e >= 255) return {sb ^ sc, 31'h7f800000, 2'b10};
         return (e < 0) ? {32'h0, 2'b01} : {sb ^ sc, 8'(e), 23'h0, 2'b00};
      end
      if (sb) return {32'h0, 2'b10};
      e = eb - 127;
      return {1'b0, 8'((e >>> 1) + 127), e[0] ? 23'h3504f3 : 23'h0, 2'b00};
   endfunction : pow2

   // one cycle: compare what is due, then drive the next request
   task automatic step(input logic v, input logic [15:0] lo, hi,
         input logic [31:0] vb, vc, input tmuz_pkg::tmuz_res_t r);
      int k;
      logic so, su, lq;
      @(negedge clk);
      k = cyc % 16;
      if (fwd_res.valid !== 1'b0 || sf[k].valid) begin
         check({fwd_res[37:2], 2'b00}, {sf[k][37:2], 2'b00});
      end
      if (short_res.valid !== 1'b0 || ss[k].valid) begin
         check(short_res, ss[k]);
      end
      if (long_res.valid !== 1'b0 || sl[k].valid) begin
         check(long_res, sl[k]);
      end
      check(38'({lovf, lunf}), 38'({e_ovf, e_unf}));
      so = ({$random(seed)} % 8) == 0;
      su = ({$random(seed)} % 8) == 0;
      // loads stay out of the delay slots of anything in flight
      lq = (cyc - last_iss > 8) && ({$random(seed)} % 4 == 0);
      {fpu_set_ovf, fpu_set_unf, flag_load} = {so, su, lq};
      {flag_load_ovf, flag_load_unf} = 2'($random(seed));
      e_ovf = (lq ? flag_load_ovf : e_ovf) | ss[k].ovf | sl[k].ovf | so;
      e_unf = (lq ? flag_load_unf : e_unf) | ss[k].unf | sl[k].unf | su;
      {sf[k], ss[k], sl[k]} = '0;
      issue_valid = v;
      instr = {hi, lo};
      tmuz_host_model_i.fregs[hi[8:6]] = vc;
      tmuz_host_model_i.fregs[hi[5:3]] = vb;
      if (r.valid) begin
         last_iss = cyc;
         // sampled at the next rising edge, so visible at the negedge latency cycles on
         if (lo == tmuz_pkg::OP_FDIV || lo == tmuz_pkg::OP_FSQRT) sl[(k + 5) % 16] = r;
         else {sf[(k + 2) % 16], ss[(k + 3) % 16]} = {r, r};
      end
      #1 check(38'(op_accept), 38'(r.valid));
   endtask : step

   task automatic op(input logic [15:0] lo, input logic [2:0] b, c, d,
         input logic [31:0] vb, vc, input logic [33:0] dfu);
      logic [2:0] cc;
      cc = (lo == tmuz_pkg::OP_FDIV) ? c : 3'h0;
      step(1'b1, lo, {7'h00, cc, b, d}, vb, vc, {1'b1, d, dfu});
   endtask : op

   task automatic idle(input int n);
      repeat (n) step(1'b0, 16'h0, 16'h0, 32'h0, 32'h0, '0);
   endtask : idle

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report

   // main sequence: reset, directed back to back, refusals, random mix
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      foreach (dir[j]) op(ops[dir[j][99:98]], 3'h1, 3'h2, 3'(4 + j % 4),
         dir[j][97:66], dir[j][65:34], dir[j][33:0]);
      idle(10);
      $display("directed done");
      step(1'b1, 16'he278, 16'h0009, 32'h3f800000, 32'h0, '0);
      step(1'b1, tmuz_pkg::OP_MUL2PI, 16'h0049, 32'h3f800000, 32'h0, '0);
      step(1'b1, tmuz_pkg::OP_FDIV, 16'h0211, 32'h3f800000, 32'h0, '0);
      idle(10);
      $display("refusal done");
      repeat (300) begin
         i = {$random(seed)} % 4;
         eb = 1 + {$random(seed)} % 254;
         ec = 1 + {$random(seed)} % 254;
         if (eb - ec == -127) eb = eb + 1;
         {sb, sc} = 2'($random(seed));
         b = 3'({$random(seed)} % 4);
         op(ops[i], b, b ^ 3'h2, 3'h4 | 3'($random(seed)), {sb, 8'(eb), 23'h0},
            {sc, 8'(ec), 23'h0}, pow2(ops[i], sb, sc, eb, ec));
         if ({$random(seed)} % 16 == 0) idle(12);
      end
      idle(12);
      $display("random done");
      final_report();
   end
endmodule : tmuz_unit_bench
